// [logic/rx_status_readback_bank.sv]
`timescale 1ns/1ps
`default_nettype none
module rx_status_readback_bank (
  // Clock and reset.
  input  wire logic                    core_clk,
  input  wire logic                    rst,
  // AHB-Lite slave.
  input  wire logic                    hsel,
  input  wire logic [31:0]             haddr,
  input  wire logic [1:0]              htrans,
  input  wire logic                    hwrite,
  input  wire logic [2:0]              hsize,
  input  wire logic [31:0]             hwdata,
  input  wire logic                    hready,
  output logic                         hreadyout,
  output logic                         hresp,
  output logic [31:0]                  hrdata,
  // Modem datapath.
  input  wire rx_readback_pkg::meas_s   meas,
  input  wire rx_readback_pkg::header_s header,
  input  wire logic                    header_update,
  input  wire logic                    packet_done,
  input  wire logic                    tx_power_update,
  input  wire logic                    receive_enable_pin,
  // Configuration seen by the datapath.
  output logic                         view_first,
  output logic [2:0]                   multipath_threshold
);

  // Address phase accepted by this slave.
  logic        take;
  // Word index and range check of the address phase.
  logic [7:0]  idx;
  logic        in_range;
  // Pending write captured in the address phase.
  logic        wr_pend_reg;
  logic [7:0]  wr_idx_reg;
  // Writable configuration registers.
  logic [7:0]  view_cfg_reg;
  logic [7:0]  mp_cfg_reg;
  // Configuration with a pending write forwarded.
  logic [7:0]  view_cfg_now;
  logic [7:0]  mp_cfg_now;
  // Latched header of the last packet.
  rx_readback_pkg::header_s hdr_reg;
  // Transmit power capture and its semaphore.
  logic [7:0]  tx_power_reg;
  logic        tx_sem_reg;
  // Quality metrics captured when receive ends.
  logic        rx_en_prev_reg;
  logic [7:0]  pkt_qual_reg;
  logic [7:0]  hdr_qual_reg;
  // Multipath metric, history and count.
  logic [7:0]  mp_metric_reg;
  logic [14:0] mp_hist_reg;
  logic [3:0]  mp_count_reg;
  logic        mp_over;
  // Read data selected for the address phase.
  logic [7:0]  rd_next;
  logic        read_tx;

  // The history shift register below is fifteen bits wide by construction.
  if (rx_readback_pkg::MP_HISTORY != 15) begin : g_history_check
    $error("History length must be fifteen.");
  end

  // Zero-wait slave that always answers OKAY.
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // A transfer is taken on NONSEQ or SEQ with the bus ready.
  // A misaligned or out-of-window address is taken but reads as zero.
  assign take     = hsel && htrans[1] && hready;
  assign idx      = haddr[9:2];
  assign in_range = (haddr[31:10] == 22'h00_0000) &&
                    (haddr[1:0] == 2'h0);
  assign read_tx  = take && !hwrite && in_range &&
                    (idx == rx_readback_pkg::IDX_TX_POWER);

  // Forward a write in its data phase so that a following read sees it.
  always_comb begin
    view_cfg_now = view_cfg_reg;
    mp_cfg_now   = mp_cfg_reg;
    if (wr_pend_reg &&
        (wr_idx_reg == rx_readback_pkg::IDX_VIEW_SEL)) begin
      // A pending view write overrides the stored value.
      view_cfg_now = hwdata[7:0];
    end
    if (wr_pend_reg &&
        (wr_idx_reg == rx_readback_pkg::IDX_MP_THR)) begin
      // A pending threshold write overrides the stored value likewise.
      mp_cfg_now = hwdata[7:0];
    end
  end

  assign view_first          = view_cfg_reg[rx_readback_pkg::VIEW_BIT];
  assign multipath_threshold =
    mp_cfg_reg[rx_readback_pkg::MP_THR_LSB +: 3];

  // Capture a write address phase; the data follows one cycle later.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      // Nothing is pending after reset.
      wr_pend_reg <= 1'b0;
      wr_idx_reg  <= 8'h00;
    end else begin
      // Only an in-range write leaves an entry for the data phase.
      wr_pend_reg <= take && hwrite && in_range;
      wr_idx_reg  <= idx;
    end
  end

  // Configuration registers written in the data phase.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      // Reset selects the second view and a zero threshold.
      view_cfg_reg <= rx_readback_pkg::CFG_RST;
      mp_cfg_reg   <= rx_readback_pkg::CFG_RST;
    end else begin
      // The forwarded value equals the stored one unless a write lands.
      view_cfg_reg <= view_cfg_now;
      mp_cfg_reg   <= mp_cfg_now;
    end
  end

  // Header fields held from one header to the next.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      hdr_reg <= '0;
    end else if (header_update) begin
      // Fields stay put between headers so software reads a whole set.
      hdr_reg <= header;
    end
  end

  // Transmit power and its semaphore; a new update wins over a read.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_power_reg <= 8'h00;
      tx_sem_reg   <= 1'b0;
    end else begin
      // Every update pulse captures a fresh power value.
      if (tx_power_update) begin
        tx_power_reg <= meas.tx_power;
      end
      // Set beats clear, so an update is never lost to a read.
      if (tx_power_update) begin
        tx_sem_reg <= 1'b1;
      end else if (read_tx) begin
        tx_sem_reg <= 1'b0;
      end
    end
  end

  // Quality metrics are sampled as receive enable falls.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rx_en_prev_reg <= 1'b0;
      pkt_qual_reg   <= 8'h00;
      hdr_qual_reg   <= 8'h00;
    end else begin
      // The previous level reveals the falling edge of receive enable.
      rx_en_prev_reg <= receive_enable_pin;
      if (rx_en_prev_reg && !receive_enable_pin) begin
        // Both metrics are final once receive enable has dropped.
        pkt_qual_reg <= meas.packet_quality;
        hdr_qual_reg <= meas.header_quality;
      end
    end
  end

  // A packet counts when its metric's top bits pass the threshold.
  assign mp_over = meas.multipath_metric[7:5] > multipath_threshold;

  // Sliding count over the last fifteen finished packets.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mp_metric_reg <= 8'h00;
      mp_hist_reg   <= 15'h0000;
      mp_count_reg  <= 4'h0;
    end else if (packet_done) begin
      mp_metric_reg <= meas.multipath_metric;
      // Shift in the newest verdict; the oldest leaves the window.
      mp_hist_reg   <= {mp_hist_reg[13:0], mp_over};
      // The count gains the newest verdict and loses the oldest.
      mp_count_reg  <= mp_count_reg + {3'h0, mp_over} -
                       {3'h0, mp_hist_reg[14]};
    end
  end

  // Read multiplexer; first view when the view bit is one.
  // Live inputs are sampled as the address phase is taken; latched
  // values come from the registers above.
  always_comb begin
    // Unmapped indices and unused bits read as zero.
    rd_next = 8'h00;
    unique case (idx)
      rx_readback_pkg::IDX_MP_THR:    rd_next = mp_cfg_now;
      rx_readback_pkg::IDX_VIEW_SEL:  rd_next = view_cfg_now;
      rx_readback_pkg::IDX_TEST_BUS:  rd_next = meas.test_bus;
      rx_readback_pkg::IDX_SIG_QUAL:  rd_next = view_first ?
        meas.noise_floor_first_antenna :
        meas.carrier_snr_quality;
      rx_readback_pkg::IDX_SIG_FIELD: rd_next = view_first ?
        meas.noise_floor_second_antenna :
        hdr_reg.signal_field;
      rx_readback_pkg::IDX_SERVICE:   rd_next = view_first ?
        meas.dc_offset_i : hdr_reg.service_field;
      rx_readback_pkg::IDX_LEN_LOW:   rd_next = view_first ?
        meas.dc_offset_q : hdr_reg.length[7:0];
      rx_readback_pkg::IDX_LEN_HIGH:  rd_next = view_first ?
        mp_metric_reg : hdr_reg.length[15:8];
      rx_readback_pkg::IDX_CRC_LOW:   rd_next = view_first ?
        {4'h0, mp_count_reg} : hdr_reg.crc[7:0];
      rx_readback_pkg::IDX_CRC_HIGH:  rd_next = view_first ?
        pkt_qual_reg : hdr_reg.crc[15:8];
      rx_readback_pkg::IDX_TX_POWER:  rd_next = tx_power_reg;
      rx_readback_pkg::IDX_MEAN_PWR:  rd_next = view_first ?
        hdr_qual_reg : meas.rx_mean_power;
      rx_readback_pkg::IDX_IF_GAIN:
        rd_next = {1'b0, meas.gain_dac};
      rx_readback_pkg::IDX_STATUS1:   rd_next = {3'h0,
        meas.energy_detect,
        tx_sem_reg,
        meas.gain_loop_locked,
        meas.gain_rail_stop_hit,
        meas.rf_gain_control_out};
      rx_readback_pkg::IDX_RSSI:
        rd_next = meas.signal_strength;
      rx_readback_pkg::IDX_STATUS2:   rd_next = {
        hdr_reg.rate,
        hdr_reg.sfd_found,
        hdr_reg.short_preamble,
        hdr_reg.signal_valid,
        hdr_reg.crc_valid,
        hdr_reg.antenna,
        1'b0};
      default: rd_next = 8'h00;
    endcase
  end

  // Read data is registered at the address-phase edge.
  // It then stands through the data phase and until the next read.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      hrdata <= rx_readback_pkg::RDATA_RST;
    end else if (take && !hwrite) begin
      // Out-of-window reads return zero rather than aliasing a register.
      hrdata <= in_range ? {24'h00_0000, rd_next} : 32'h0000_0000;
    end
  end

  // Checks on the logic above.
  // An update pulse always leaves the semaphore set.
  a_sem_set_update: assert property (@(posedge core_clk)
    disable iff (rst) tx_power_update |=> tx_sem_reg)
    else $error("Semaphore not set after a power update.");

  // A power read without a new update clears the semaphore.
  a_sem_clear_read: assert property (@(posedge core_clk)
    disable iff (rst) read_tx && !tx_power_update |=> !tx_sem_reg)
    else $error("Semaphore not cleared by a read.");

  // A power read returns the captured value in either view.
  a_tx_power_view: assert property (@(posedge core_clk)
    disable iff (rst) read_tx |=> hrdata[7:0] == $past(tx_power_reg))
    else $error("Power read does not match capture.");

  // The first view shows the live first-antenna noise floor.
  a_first_view_noise: assert property (@(posedge core_clk)
    disable iff (rst) take && !hwrite && in_range && view_first &&
    idx == rx_readback_pkg::IDX_SIG_QUAL |=>
    hrdata[7:0] == $past(meas.noise_floor_first_antenna))
    else $error("First view noise floor wrong.");

  // The second view shows the latched header CRC low byte.
  a_second_view_crc: assert property (@(posedge core_clk)
    disable iff (rst) take && !hwrite && in_range && !view_first &&
    idx == rx_readback_pkg::IDX_CRC_LOW |=>
    hrdata[7:0] == $past(hdr_reg.crc[7:0]))
    else $error("Second view CRC low wrong.");

  // Header fields never move without a latch pulse.
  a_header_hold: assert property (@(posedge core_clk)
    disable iff (rst) !header_update |=> $stable(hdr_reg))
    else $error("Header changed without an update.");

  // A latch pulse takes the whole header at once.
  a_header_load: assert property (@(posedge core_clk)
    disable iff (rst) header_update |=> hdr_reg == $past(header))
    else $error("Header not loaded.");

  // Unused bits of the first status register read as zero.
  a_status1_unused: assert property (@(posedge core_clk)
    disable iff (rst) take && !hwrite && in_range &&
    idx == rx_readback_pkg::IDX_STATUS1 |=> hrdata[31:5] == '0)
    else $error("Unused status bits not zero.");

  // The count always equals the verdicts held in the window.
  a_mp_count_bound: assert property (@(posedge core_clk)
    disable iff (rst) int'(mp_count_reg) == $countones(mp_hist_reg))
    else $error("Multipath count inconsistent.");

  // A landed view write drives the view bit.
  a_view_write: assert property (@(posedge core_clk)
    disable iff (rst) wr_pend_reg &&
    wr_idx_reg == rx_readback_pkg::IDX_VIEW_SEL |=>
    view_first == $past(hwdata[7]))
    else $error("View bit not written.");

  // Packet quality follows its measurement as receive ends.
  a_quality_latch: assert property (@(posedge core_clk)
    disable iff (rst) rx_en_prev_reg && !receive_enable_pin |=>
    pkt_qual_reg == $past(meas.packet_quality))
    else $error("Packet quality not captured.");

  // The metric of the last finished packet is kept.
  a_mp_metric_load: assert property (@(posedge core_clk)
    disable iff (rst) packet_done |=>
    mp_metric_reg == $past(meas.multipath_metric))
    else $error("Multipath metric not captured.");

  // The unused top bit of the gain readback stays low.
  a_gain_top_zero: assert property (@(posedge core_clk)
    disable iff (rst) take && !hwrite && in_range &&
    idx == rx_readback_pkg::IDX_IF_GAIN |=> !hrdata[7])
    else $error("Gain readback top bit set.");

  // The spare bit of the second status register stays low.
  a_status2_spare: assert property (@(posedge core_clk)
    disable iff (rst) take && !hwrite && in_range &&
    idx == rx_readback_pkg::IDX_STATUS2 |=> !hrdata[0])
    else $error("Second status spare bit set.");

  // Main scenarios that the bench should reach.
  // A pending semaphore is consumed by a power read.
  c_tx_read: cover property (@(posedge core_clk)
    disable iff (rst) tx_sem_reg ##1 read_tx);
  // Software switches from the first view to the second.
  c_view_flip: cover property (@(posedge core_clk)
    disable iff (rst) view_first ##[1:20] !view_first);
  // Some but not all recent packets exceed the threshold.
  c_mp_count: cover property (@(posedge core_clk)
    disable iff (rst) mp_count_reg == 4'h3);
  // A header latch followed by a read of the second status.
  c_header_read: cover property (@(posedge core_clk)
    disable iff (rst) header_update ##[1:20]
    (take && idx == rx_readback_pkg::IDX_STATUS2));
  // A full window of packets over the threshold.
  c_mp_full: cover property (@(posedge core_clk)
    disable iff (rst) mp_count_reg == 4'hf);

endmodule
`default_nettype wire

// [logic/rx_readback_pkg.sv]
`default_nettype none
package rx_readback_pkg;

  // Register indices; the byte address is four times the index.
  localparam logic [7:0] IDX_MP_THR    = 8'h48;
  localparam logic [7:0] IDX_VIEW_SEL  = 8'h62;
  localparam logic [7:0] IDX_TEST_BUS  = 8'h64;
  localparam logic [7:0] IDX_SIG_QUAL  = 8'h66;
  localparam logic [7:0] IDX_SIG_FIELD = 8'h68;
  localparam logic [7:0] IDX_SERVICE   = 8'h6a;
  localparam logic [7:0] IDX_LEN_LOW   = 8'h6c;
  localparam logic [7:0] IDX_LEN_HIGH  = 8'h6e;
  localparam logic [7:0] IDX_CRC_LOW   = 8'h70;
  localparam logic [7:0] IDX_CRC_HIGH  = 8'h72;
  localparam logic [7:0] IDX_TX_POWER  = 8'h74;
  localparam logic [7:0] IDX_MEAN_PWR  = 8'h78;
  localparam logic [7:0] IDX_IF_GAIN   = 8'h7a;
  localparam logic [7:0] IDX_STATUS1   = 8'h7c;
  localparam logic [7:0] IDX_RSSI      = 8'h7e;
  localparam logic [7:0] IDX_STATUS2   = 8'h80;

  // Field positions and reset values.
  localparam int          VIEW_BIT     = 7;
  localparam int          MP_THR_LSB   = 5;
  localparam logic [7:0]  CFG_RST      = 8'h00;
  localparam int          MP_HISTORY   = 15;
  localparam logic [31:0] RDATA_RST    = 32'h0000_0000;

  // Measurements arriving continuously from the modem datapath.
  typedef struct packed {
    logic [7:0] test_bus;
    logic [7:0] noise_floor_first_antenna;
    logic [7:0] noise_floor_second_antenna;
    logic [7:0] carrier_snr_quality;
    logic [7:0] dc_offset_i;
    logic [7:0] dc_offset_q;
    logic [7:0] multipath_metric;
    logic [7:0] packet_quality;
    logic [7:0] header_quality;
    logic [7:0] tx_power;
    logic [7:0] rx_mean_power;
    logic [6:0] gain_dac;
    logic [7:0] signal_strength;
    logic       energy_detect;
    logic       gain_loop_locked;
    logic       gain_rail_stop_hit;
    logic       rf_gain_control_out;
  } meas_s;

  // Fields of one decoded packet header.
  typedef struct packed {
    logic [7:0]  signal_field;
    logic [7:0]  service_field;
    logic [15:0] length;
    logic [15:0] crc;
    logic [1:0]  rate;
    logic        sfd_found;
    logic        short_preamble;
    logic        signal_valid;
    logic        crc_valid;
    logic        antenna;
  } header_s;

endpackage
`default_nettype wire

// [tb/rx_status_readback_bank_tb.sv]
`timescale 1ns/1ps
`default_nettype none
// Compares two values, counts the compare and reports any mismatch.
`define CHK(got, exp) begin \
  samples_checked++; \
  if ((got) !== (exp)) begin \
    mismatches++; \
    $display("Error at %0t: got %h expected %h", $time, got, exp); \
  end \
end
module rx_status_readback_bank_tb;
  // One table row: view bit, register index and expected byte.
  typedef struct packed {
    logic       v;
    logic [7:0] idx;
    logic [7:0] exp;
  } row_s;
  logic                    core_clk;         // Bench clock.
  logic                    rst;              // Synchronous reset.
  logic                    hsel;             // Bus select.
  logic [31:0]             haddr;            // Byte address.
  logic [1:0]              htrans;           // Transfer type.
  logic                    hwrite;           // Write strobe.
  logic [2:0]              hsize;            // Transfer size.
  logic [31:0]             hwdata;           // Write data.
  logic                    hready;           // Bus ready loop.
  logic                    hreadyout;        // Slave ready.
  logic                    hresp;            // Slave response.
  logic [31:0]             hrdata;           // Read data.
  rx_readback_pkg::meas_s   meas;             // Live measurements.
  rx_readback_pkg::header_s header;           // Decoded header.
  logic                    header_update;    // Header latch pulse.
  logic                    packet_done;      // Packet end pulse.
  logic                    tx_power_update;  // Transmit power pulse.
  logic                    receive_enable_pin; // Receive enable level.
  logic                    view_first;       // View bit output.
  logic [2:0]              multipath_threshold; // Threshold output.
  int                      mismatches;       // Mismatch count.
  int                      samples_checked;  // Compare count.
  logic [7:0]              d;                // Last read byte.
  logic [1:0]              r;                // Rate code under test.
  // Ordinary cases, walked in order; later rows see earlier side effects.
  row_s rows [28] = '{
    '{1'b1, 8'h64, 8'h11}, '{1'b0, 8'h64, 8'h11},
    '{1'b1, 8'h66, 8'h21}, '{1'b0, 8'h66, 8'h43},
    '{1'b1, 8'h68, 8'h32}, '{1'b0, 8'h68, 8'h0a},
    '{1'b1, 8'h6a, 8'h54}, '{1'b0, 8'h6a, 8'h1b},
    '{1'b1, 8'h6c, 8'h65}, '{1'b0, 8'h6c, 8'h3d},
    '{1'b1, 8'h6e, 8'hf0}, '{1'b0, 8'h6e, 8'h2c},
    '{1'b1, 8'h70, 8'h03}, '{1'b0, 8'h70, 8'h5f},
    '{1'b1, 8'h72, 8'h87}, '{1'b0, 8'h72, 8'h4e},
    '{1'b1, 8'h7c, 8'h1a}, '{1'b1, 8'h74, 8'ha9},
    '{1'b0, 8'h7c, 8'h12}, '{1'b0, 8'h74, 8'ha9},
    '{1'b1, 8'h78, 8'h98}, '{1'b0, 8'h78, 8'hba},
    '{1'b1, 8'h7a, 8'h5d}, '{1'b0, 8'h7a, 8'h5d},
    '{1'b1, 8'h7e, 8'hcb}, '{1'b0, 8'h7e, 8'hcb},
    '{1'b0, 8'h80, 8'haa}, '{1'b1, 8'h80, 8'haa}
  };
  // The single slave's ready is the bus ready.
  assign hready = hreadyout;
  rx_status_readback_bank i_dut (
    .core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .meas(meas), .header(header),
    .header_update(header_update), .packet_done(packet_done),
    .tx_power_update(tx_power_update),
    .receive_enable_pin(receive_enable_pin), .view_first(view_first),
    .multipath_threshold(multipath_threshold)
  );
  // Clock generator, 10 ns period.
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Prints the counts and the verdict, then stops the run.
  task automatic summarize();
    $display("Compares %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Single word read: address phase, then data phase, data at its end.
  task automatic rd(input logic [7:0] idx, output logic [7:0] q);
    @(posedge core_clk);
    hsel   <= 1'b1;
    haddr  <= {22'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= 1'b0;
    do @(posedge core_clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    do @(posedge core_clk); while (hready !== 1'b1);
    q = hrdata[7:0];
    `CHK(hrdata[31:8], 24'h000000)
    `CHK(hresp, 1'b0)
  endtask
  // Single word write: address phase, then write data in the data phase.
  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    @(posedge core_clk);
    hsel   <= 1'b1;
    haddr  <= {22'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= 1'b1;
    do @(posedge core_clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, v};
    do @(posedge core_clk); while (hready !== 1'b1);
  endtask
  // One-cycle datapath pulse: 0 header, 1 packet end, 2 transmit power.
  task automatic pulse(input int k);
    @(posedge core_clk);
    header_update   <= (k == 0);
    packet_done     <= (k == 1);
    tx_power_update <= (k == 2);
    @(posedge core_clk);
    header_update   <= 1'b0;
    packet_done     <= 1'b0;
    tx_power_update <= 1'b0;
  endtask
  // Watchdog: the whole sequence needs well under 5000 cycles.
  initial begin
    repeat (5000) @(posedge core_clk);
    mismatches++;
    summarize();
  end
  // Main sequence: setup, table, then hand-written cases.
  initial begin
    mismatches = 0;
    samples_checked = 0;
    rst = 1'b1;
    {hsel, htrans, hwrite, haddr, hwdata} = '0;
    hsize = 3'b010;
    meas = '0;
    header = '0;
    {header_update, packet_done, tx_power_update} = 3'b000;
    receive_enable_pin = 1'b1;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    meas <= '{8'h11, 8'h21, 8'h32, 8'h43, 8'h54, 8'h65, 8'h00, 8'h87,
              8'h98, 8'ha9, 8'hba, 7'h5d, 8'hcb, 1'b1, 1'b0, 1'b1, 1'b0};
    header <= '{8'h0a, 8'h1b, 16'h2c3d, 16'h4e5f, 2'b10,
                1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
    wr(8'h48, 8'h60);
    #1 `CHK(multipath_threshold, 3'd3)
    pulse(0);
    // New header values without a latch pulse must not show.
    header <= '{8'hff, 8'hff, 16'hffff, 16'hffff, 2'b01,
                1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    foreach (rows[i]) begin
      if (i < 4) begin
        meas.multipath_metric <= (i == 2) ? 8'h60 : 8'hf0;
        pulse(1);
      end
    end
    pulse(2);
    receive_enable_pin <= 1'b0;
    wr(8'h62, 8'h80);
    #1 `CHK(view_first, 1'b1)
    foreach (rows[i]) begin
      wr(8'h62, {rows[i].v, 7'h00});
      rd(rows[i].idx, d);
      `CHK(d, rows[i].exp)
    end
    $display("Test table done");
    // Inverted status inputs with the semaphore already cleared.
    @(posedge core_clk);
    meas.energy_detect       <= 1'b0;
    meas.gain_loop_locked    <= 1'b1;
    meas.gain_rail_stop_hit  <= 1'b0;
    meas.rf_gain_control_out <= 1'b1;
    rd(8'h7c, d);
    `CHK(d, 8'h05)
    $display("Test status bits done");
    // Every rate code with changing flag patterns.
    for (int k = 0; k < 4; k++) begin
      r = k[1:0];
      header <= '{8'h00, 8'h00, 16'h0, 16'h0, r, r[0], ~r[0],
                  r[1], ~r[1], r[0]};
      pulse(0);
      rd(8'h80, d);
      `CHK(d, {r, r[0], ~r[0], r[1], ~r[1], r[0], 1'b0})
    end
    $display("Test rate codes done");
    // A write to a read-only place and a read of an unmapped place.
    wr(8'h64, 8'hff);
    rd(8'h64, d);
    `CHK(d, 8'h11)
    rd(8'h90, d);
    `CHK(d, 8'h00)
    $display("Test refused access done");
    // Only the last 15 packets count: 16 over, then 15 under.
    wr(8'h62, 8'h80);
    meas.multipath_metric <= 8'hf0;
    repeat (16) pulse(1);
    rd(8'h70, d);
    `CHK(d, 8'h0f)
    meas.multipath_metric <= 8'h20;
    repeat (15) pulse(1);
    rd(8'h70, d);
    `CHK(d, 8'h00)
    $display("Test multipath window done");
    // Second reset in mid-run returns the second view and clears latches.
    @(posedge core_clk);
    rst <= 1'b1;
    @(posedge core_clk);
    rst <= 1'b0;
    #1 `CHK(view_first, 1'b0)
    rd(8'h62, d);
    `CHK(d, 8'h00)
    rd(8'h80, d);
    `CHK(d, 8'h00)
    $display("Test mid-run reset done");
    summarize();
  end
endmodule
`default_nettype wire
